// ---- diag_consts.vh ----
// Constants for the fieldbus slave diagnostic response builder
`ifndef DIAG_CONSTS_VH
`define DIAG_CONSTS_VH
// Register byte offsets
`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_IRQ_STAT  8'h08
`define OFF_IRQ_MASK  8'h0c
`define OFF_IDENT     8'h10
`define OFF_MSG       8'h14
`define OFF_USER      8'h18
`define OFF_USER_DATA 8'h1c
`define OFF_MASTER    8'h20
// Station status byte 0 fields
`define S0_NOT_READY  1
`define S0_CFG_FAULT  2
`define S0_EXT_DIAG   3
`define S0_UNSUPP     4
`define S0_BAD_PARAM  6
// Station status byte 1 fields
`define S1_NEED_PARAM 0
`define S1_STATIC     1
`define S1_FIXED_ONE  2
`define S1_WATCHDOG   3
`define S1_FREEZE     4
`define S1_SYNC       5
// Station status byte 2 field
`define S2_OVERFLOW   7
// Device-specific header: length 10, code 00
`define DEV_HDR       8'h0a
// Message codes
`define MSG_PRM_LEN   8'h12
`define MSG_CFG_LEN   8'h13
`define MSG_CFG_ENTRY 8'h14
`define MSG_BUF_CALC  8'h15
`define MSG_NO_CFG    8'h16
`define MSG_MISMATCH  8'h17
`define MSG_USER_OK   8'h40
// Host status byte
`define HST_VALID     0
`define HST_DELETE    1
`define HST_IGNORED   8'h03
// Response framing
`define DIAG_LEN      5'd16
`define USER_FIRST    5'd11
// Interrupt bits
`define IRQ_SENT      0
`define IRQ_AUTO      1
`define IRQ_OVF       2
`define IDENT_RESET   16'h1234
`endif

// ---- diag_trigger.v ----
// Host status byte edge detector that starts a user diagnostic
`include "diag_consts.vh"
module diag_trigger (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire       wr_stb,
   input  wire [7:0] status_new,
   output reg  [7:0] status_reg,
   output reg        start_pulse
);
   // Valid bit 0->1 starts sending; pattern 03 never starts
   always @(posedge aclk) begin
      if (!aresetn) begin
         status_reg  <= 8'h00;
         start_pulse <= 1'b0;
      end else begin
         start_pulse <= 1'b0;
         if (wr_stb) begin
            status_reg <= status_new;
            if (!status_reg[`HST_VALID] && status_new[`HST_VALID]
                && status_new != `HST_IGNORED) begin
               start_pulse <= 1'b1;
            end
         end
      end
   end
endmodule

// ---- diag_serializer.v ----
// Streams the 16-byte response one byte per accepted beat
`include "diag_consts.vh"
module diag_serializer (
   input  wire         aclk,
   input  wire         aresetn,
   input  wire         start,
   input  wire [127:0] frame,
   input  wire         tx_ready,
   output reg          tx_valid,
   output reg  [7:0]   tx_data,
   output reg          tx_last,
   output wire         busy
);
   reg [127:0] shift_reg;
   reg [4:0]   left_reg;
   assign busy = (left_reg != 5'd0);
   // Frame latched at start so later host writes cannot tear it
   always @(posedge aclk) begin
      if (!aresetn) begin
         shift_reg <= 128'h0;
         left_reg  <= 5'd0;
         tx_valid  <= 1'b0;
         tx_data   <= 8'h00;
         tx_last   <= 1'b0;
      end else if (!busy && start) begin
         shift_reg <= {8'h00, frame[127:8]};
         tx_data   <= frame[7:0];
         tx_valid  <= 1'b1;
         tx_last   <= 1'b0;
         left_reg  <= `DIAG_LEN;
      end else if (tx_valid && tx_ready) begin
         left_reg  <= left_reg - 5'd1;
         tx_data   <= shift_reg[7:0];
         shift_reg <= {8'h00, shift_reg[127:8]};
         tx_valid  <= (left_reg != 5'd1);
         tx_last   <= (left_reg == 5'd2);
      end
   end
endmodule

// ---- diag_builder.v ----
// Fieldbus slave diagnostic response builder with AXI4-Lite registers
//
// Contract
// - A response is sent on each master request and on its own when an error arises; a start while one runs and one waits is dropped.
// - Bytes 0 to 5 hold station status and bytes 6 to 15 hold device-specific data.
// - Bytes 11 to 15 come from host-writable user data registers.
// - The host can start a transmission and change the user data through registers.
// - Byte 0 carries not-ready, config fault, ext diag, unsupported, bad param; bits 0,5,7 zero.
// - Byte 1 carries need-param, static, watchdog; bit 2 is one, bits 6 and 7 zero.
// - Byte 1 bits 4 and 5 set once freeze or sync commands arrive.
// - Byte 2 bit 7 flags overflow, bits 0 to 6 are reserved zero.
// - Byte 3 holds the master address captured at parametrization.
// - Byte 6 is length and code, byte 7 the message, bytes 8 to 10 reserved zero.
// - Slave input area maps to master output area and vice versa.
// - Byte 7 reports codes 12h to 17h for errors and 40h for valid user data.
// - A 0 to 1 change of the host status byte starts sending, but value 03 is ignored.
// - Host status bit 0 marks user data valid, bit 1 deletes the diagnostic.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`include "diag_consts.vh"
module diag_builder (
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Protocol engine events, same clock
   input  wire        diag_req,
   input  wire        prm_done,
   input  wire [7:0]  prm_master_addr,
   input  wire        freeze_cmd,
   input  wire        sync_cmd,
   input  wire        not_ready,
   input  wire        cfg_fault,
   input  wire        unsupported,
   input  wire        bad_param,
   input  wire        need_param,
   input  wire        watchdog_on,
   input  wire [2:0]  fault_code,
   // Response byte stream towards the bus master
   output wire        tx_valid,
   input  wire        tx_ready,
   output wire [7:0]  tx_data,
   output wire        tx_last,
   output wire        irq
);
   // Write channel capture
   reg         aw_held_reg;
   reg         w_held_reg;
   reg  [7:0]  awaddr_reg;
   reg  [31:0] wdata_reg;
   reg  [3:0]  wstrb_reg;

   // Host registers and latched events
   reg  [7:0]  ctrl_reg;
   reg  [15:0] ident_reg;
   reg  [39:0] user_reg;
   reg  [7:0]  master_reg;
   reg         freeze_reg;
   reg         sync_reg;
   reg         overflow_reg;
   reg         pend_reg;
   reg  [2:0]  irq_stat_reg;
   reg  [2:0]  irq_mask_reg;
   reg  [2:0]  fault_last_reg;

   // Internal strobes
   wire [7:0]  host_status;
   wire        host_start;
   wire        busy;
   wire        do_write;
   wire        wr_user;
   wire        auto_err;
   wire        want_send;
   wire        sent;
   wire        ctrl_send;
   wire        ser_start;
   wire        ovf_event;
   wire        stat_clr;

   // Response assembly
   reg  [7:0]  msg_code;
   wire [7:0]  byte0;
   wire [7:0]  byte1;
   wire [7:0]  byte2;
   wire [127:0] frame;
   wire [31:0] wmask;

   // Write channels taken in either order, held until both are in
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                   {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   assign wr_user = do_write && awaddr_reg == `OFF_USER && wstrb_reg[0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         awaddr_reg   <= 8'h00;
         wdata_reg    <= 32'h0;
         wstrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Read-only and unmapped offsets answer SLVERR and change nothing
            case (awaddr_reg)
               `OFF_CTRL, `OFF_IRQ_STAT, `OFF_IRQ_MASK, `OFF_IDENT,
               `OFF_USER, `OFF_USER_DATA: s_axi_bresp <= 2'b00;
               default: s_axi_bresp <= 2'b10;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Host-written registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg     <= 8'h00;
         ident_reg    <= `IDENT_RESET;
         user_reg     <= 40'h0;
         irq_mask_reg <= 3'h0;
      end else if (do_write) begin
         case (awaddr_reg)
            `OFF_CTRL: ctrl_reg <= (ctrl_reg & ~wmask[7:0]) | (wdata_reg[7:0] & wmask[7:0]);
            `OFF_IRQ_MASK: irq_mask_reg <= wdata_reg[2:0] & wmask[2:0];
            `OFF_IDENT: ident_reg <= (ident_reg & ~wmask[15:0])
                                   | (wdata_reg[15:0] & wmask[15:0]);
            `OFF_USER: user_reg[7:0] <= (user_reg[7:0] & ~wmask[15:8])
                                      | (wdata_reg[15:8] & wmask[15:8]);
            `OFF_USER_DATA: user_reg[39:8] <= (user_reg[39:8] & ~wmask)
                                            | (wdata_reg & wmask);
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // Status byte lives in byte lane 0 of the user register
   diag_trigger u_trigger (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .wr_stb      (wr_user),
      .status_new  (wdata_reg[7:0]),
      .status_reg  (host_status),
      .start_pulse (host_start)
   );

   // A change to a nonzero fault code raises an unsolicited diagnostic
   assign auto_err  = (fault_code != 3'd0) && (fault_code != fault_last_reg);
   assign ctrl_send = do_write && awaddr_reg == `OFF_CTRL && wstrb_reg[0] && wdata_reg[0];
   assign want_send = diag_req || host_start || auto_err || ctrl_send;
   assign sent      = tx_valid && tx_ready && tx_last;
   // A start refused while one already waits is lost, so it is flagged
   assign ovf_event = want_send && busy && pend_reg;
   // A waiting request goes out as soon as the serializer is idle
   assign ser_start = want_send || pend_reg;
   assign stat_clr  = do_write && awaddr_reg == `OFF_IRQ_STAT;

   // Latched events; a set beats a clear in the same cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         master_reg     <= 8'h00;
         freeze_reg     <= 1'b0;
         sync_reg       <= 1'b0;
         overflow_reg   <= 1'b0;
         pend_reg       <= 1'b0;
         fault_last_reg <= 3'd0;
         irq_stat_reg   <= 3'h0;
      end else begin
         fault_last_reg <= fault_code;
         if (prm_done) begin
            master_reg <= prm_master_addr;
            freeze_reg <= 1'b0;
            sync_reg   <= 1'b0;
         end
         if (freeze_cmd) freeze_reg <= 1'b1;
         if (sync_cmd) sync_reg <= 1'b1;
         // Flag rides in the waiting frame's snapshot, then clears
         if (ovf_event) overflow_reg <= 1'b1;
         else if (!busy && pend_reg) overflow_reg <= 1'b0;
         if (want_send && busy) pend_reg <= 1'b1;
         else if (!busy) pend_reg <= 1'b0;
         // Clear first, so an event in the same cycle still lands
         if (stat_clr)
            irq_stat_reg <= irq_stat_reg & ~(wdata_reg[2:0] & wmask[2:0]);
         if (sent) irq_stat_reg[`IRQ_SENT] <= 1'b1;
         if (auto_err) irq_stat_reg[`IRQ_AUTO] <= 1'b1;
         if (ovf_event) irq_stat_reg[`IRQ_OVF] <= 1'b1;
      end
   end

   // Level interrupt while any unmasked status bit is set
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // Message code: errors first, then valid user data unless deleted
   always @* begin
      case (fault_code)
         3'd1: msg_code = `MSG_PRM_LEN;
         3'd2: msg_code = `MSG_CFG_LEN;
         3'd3: msg_code = `MSG_CFG_ENTRY;
         3'd4: msg_code = `MSG_BUF_CALC;
         3'd5: msg_code = `MSG_NO_CFG;
         3'd6: msg_code = `MSG_MISMATCH;
         default: msg_code = (host_status[`HST_VALID] && !host_status[`HST_DELETE])
                             ? `MSG_USER_OK : 8'h00;
      endcase
   end

   // Station status bytes; fixed bits wired, reserved bits zero
   assign byte0 = {1'b0, bad_param, 1'b0, unsupported, ctrl_reg[1],
                   cfg_fault, not_ready, 1'b0};
   assign byte1 = {2'b00, sync_reg, freeze_reg, watchdog_on, 1'b1,
                   ctrl_reg[2], need_param};
   assign byte2 = {overflow_reg, 7'h00};
   // Byte 0 in the low lane so it leaves first
   // User lanes pass straight from the host's side to the master's view
   assign frame = {user_reg[39:8],            // bytes 12..15
                   user_reg[7:0],             // byte 11
                   8'h00,                     // byte 10
                   8'h00,                     // byte 9
                   8'h00,                     // byte 8
                   msg_code,                  // byte 7
                   `DEV_HDR,                  // byte 6
                   ident_reg[7:0],            // byte 5
                   ident_reg[15:8],           // byte 4
                   master_reg, byte2, byte1, byte0};

   // Snapshot at start keeps a frame whole while the host rewrites it
   diag_serializer u_ser (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .start    (ser_start),
      .frame    (frame),
      .tx_ready (tx_ready),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .tx_last  (tx_last),
      .busy     (busy)
   );

   // Read channel, one outstanding read
   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         // Unmapped offsets read zero and answer SLVERR
         case (s_axi_araddr)
            `OFF_CTRL:      s_axi_rdata <= {24'h0, ctrl_reg};
            `OFF_STATUS:    s_axi_rdata <= {byte0, byte1, byte2, 5'h0, pend_reg,
                                            overflow_reg, busy};
            `OFF_IRQ_STAT:  s_axi_rdata <= {29'h0, irq_stat_reg};
            `OFF_IRQ_MASK:  s_axi_rdata <= {29'h0, irq_mask_reg};
            `OFF_IDENT:     s_axi_rdata <= {16'h0, ident_reg};
            `OFF_MSG:       s_axi_rdata <= {24'h0, msg_code};
            `OFF_USER:      s_axi_rdata <= {16'h0, user_reg[7:0], host_status};
            `OFF_USER_DATA: s_axi_rdata <= user_reg[39:8];
            `OFF_MASTER:    s_axi_rdata <= {24'h0, master_reg};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ---- diag_builder_monitor.sv ----
// Port checker for the diagnostic response builder
module diag_builder_monitor (
   input logic       aclk,
   input logic       aresetn,
   input logic       diag_req,
   input logic [2:0] fault_code,
   input logic       tx_valid,
   input logic       tx_ready,
   input logic [7:0] tx_data,
   input logic       tx_last,
   input logic       s_axi_arvalid,
   input logic       s_axi_arready,
   input logic       s_axi_rvalid
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] beat;
   // Byte position on the wire, so each check knows which byte it sees
   always_ff @(posedge aclk) begin
      if (!aresetn)
         beat <= 4'h0;
      else if (tx_valid && tx_ready)
         beat <= tx_last ? 4'h0 : beat + 4'h1;
   end
   // Frame content, start and read-channel checks
   property p_req; !tx_valid && diag_req |=> tx_valid; endproperty
   property p_auto; !tx_valid && fault_code != 3'h0 && fault_code != $past(fault_code)
      |=> tx_valid; endproperty
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
   property p_last; tx_valid |-> tx_last == (beat == 4'd15); endproperty
   property p_b0; tx_valid && beat == 4'd0 |-> !tx_data[0] && !tx_data[5] && !tx_data[7];
   endproperty
   property p_b1; tx_valid && beat == 4'd1 |-> tx_data[2] && !tx_data[7]; endproperty
   property p_b2; tx_valid && beat == 4'd2 |-> tx_data[6:0] == 7'h00; endproperty
   property p_hdr; tx_valid && beat == 4'd6 |-> tx_data == 8'h0a; endproperty
   property p_resv; tx_valid && beat inside {[4'd8:4'd10]} |-> tx_data == 8'h00; endproperty
   property p_msg; tx_valid && beat == 4'd7 |-> tx_data inside {8'h00, [8'h12:8'h17], 8'h40};
   endproperty
   property p_rd; s_axi_arvalid && s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid; endproperty
   a_req: assert property (p_req) else $error("request did not start a frame");
   a_auto: assert property (p_auto) else $error("fault did not start a frame");
   a_hold: assert property (p_hold) else $error("byte changed while stalled");
   a_last: assert property (p_last) else $error("last flag off byte 15");
   a_b0: assert property (p_b0) else $error("byte 0 fixed bits wrong");
   a_b1: assert property (p_b1) else $error("byte 1 fixed bits wrong");
   a_b2: assert property (p_b2) else $error("byte 2 reserved bits set");
   a_hdr: assert property (p_hdr) else $error("byte 6 header wrong");
   a_resv: assert property (p_resv) else $error("reserved byte not zero");
   a_msg: assert property (p_msg) else $error("message code out of set");
   a_rd: assert property (p_rd) else $error("read not answered");
   // Main scenarios reached
   c_stall: cover property (tx_valid && !tx_ready);
   c_end: cover property (tx_valid && tx_ready && tx_last);
   c_rd: cover property (s_axi_rvalid);
endmodule

bind diag_builder diag_builder_monitor u_mon (.aclk, .aresetn, .diag_req, .fault_code,
   .tx_valid, .tx_ready, .tx_data, .tx_last, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ---- diag_poll_master.sv ----
// Bus master model that accepts and collects response frames
module diag_poll_master (
   input  logic         aclk,
   input  logic         aresetn,
   input  logic         slow,
   input  logic         tx_valid,
   input  logic [7:0]   tx_data,
   input  logic         tx_last,
   output logic         tx_ready,
   output logic [127:0] frame,
   output logic [7:0]   frames
);
   logic [3:0] pos;
   // Slow mode stalls every other cycle so the hold rule gets exercised
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_ready <= 1'b0;
         pos <= 4'h0;
         frames <= 8'h00;
         frame <= '0;
      end else begin
         tx_ready <= slow ? !tx_ready : 1'b1;
         if (tx_valid && tx_ready) begin
            frame[8*pos +: 8] <= tx_data;
            pos <= tx_last ? 4'h0 : pos + 4'h1;
            if (tx_last)
               frames <= frames + 8'h01;
         end
      end
   end
endmodule

// ---- tb_diag_builder.sv ----
// Self-checking bench for the diagnostic response builder
`include "diag_consts.vh"
module tb_diag_builder;
   timeunit 1ns;
   timeprecision 1ps;
   logic         aclk, aresetn, slow, diag_req, prm_done, freeze_cmd, sync_cmd;
   logic [7:0]   s_axi_awaddr, s_axi_araddr, prm_master_addr;
   logic [31:0]  s_axi_wdata;
   logic [3:0]   s_axi_wstrb;
   logic         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [5:0]   lv;
   logic [2:0]   fault_code;
   wire          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]   s_axi_bresp, s_axi_rresp;
   wire  [31:0]  s_axi_rdata;
   wire          tx_valid, tx_ready, tx_last, irq;
   wire  [7:0]   tx_data, frames;
   wire  [127:0] fr;
   int           fail_count, n_checks, nf;
   diag_builder DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .diag_req, .prm_done, .prm_master_addr,
      .freeze_cmd, .sync_cmd, .not_ready(lv[5]), .cfg_fault(lv[4]), .unsupported(lv[3]),
      .bad_param(lv[2]), .need_param(lv[1]), .watchdog_on(lv[0]), .fault_code, .tx_valid,
      .tx_ready, .tx_data, .tx_last, .irq);
   diag_poll_master far_end (.aclk, .aresetn, .slow, .tx_valid, .tx_data, .tx_last,
      .tx_ready, .frame(fr), .frames);
   // 125 MHz clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic timed_out;
      fail_count++;
      $display("CHECK FAILED wait expected answer seen none");
      conclude();
   endtask
   task automatic chkb(int i, logic [7:0] e);
      chk($sformatf("byte %0d", i), fr[8*i +: 8], e);
   endtask
   // Write cycle: address and data offered together, each released once taken
   task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) timed_out();
      chk("bresp", s_axi_bresp, er);
   endtask
   task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 50) timed_out();
   endtask
   // Frames finish at the far end's pace, so the wait is bounded, not fixed
   task automatic wait_frames(int k);
      int n;
      nf += k;
      for (n = 0; n < 2000 && frames !== nf[7:0]; n++) @(posedge aclk);
      if (n == 2000) timed_out();
   endtask
   initial begin
      int p, c;
      logic [31:0] d;
      logic [1:0] r;
      {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {diag_req, prm_done, freeze_cmd, sync_cmd, lv, fault_code, prm_master_addr} = '0;
      fail_count = 0;
      n_checks = 0;
      nf = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`OFF_IDENT, d, r);
      chk("ident", d[15:0], `IDENT_RESET);
      rd(8'h40, d, r);
      chk("unmapped rresp", r, 2'h2);
      wr(8'h40, 32'h0, 4'hf, 2'h2);
      $display("test registers done");
      // Parametrize from station 5, then freeze and sync
      @(posedge aclk);
      prm_done <= 1'b1;
      prm_master_addr <= 8'h05;
      @(posedge aclk);
      prm_done <= 1'b0;
      freeze_cmd <= 1'b1;
      sync_cmd <= 1'b1;
      @(posedge aclk);
      freeze_cmd <= 1'b0;
      sync_cmd <= 1'b0;
      wr(`OFF_IDENT, 32'habcd, 4'hf, 2'h0);
      for (p = 0; p < 2; p++) begin
         lv <= p ? 6'b101010 : 6'b010101;
         slow <= p[0];
         // Status bits settle before the send (control write in pass 0, diag_req in pass 1), which snapshots the frame
         wr(`OFF_CTRL, {29'h0, p[0], !p[0], 1'b0}, 4'h1, 2'h0);
         wr(`OFF_CTRL, {29'h0, p[0], !p[0], !p[0]}, 4'h1, 2'h0);
         if (p) begin
            @(posedge aclk);
            diag_req <= 1'b1;
            @(posedge aclk);
            diag_req <= 1'b0;
         end
         wait_frames(1);
         chkb(0, p ? 8'h12 : 8'h4c);
         chkb(1, p ? 8'h37 : 8'h3c);
         chkb(2, 8'h00);
         chkb(3, 8'h05);
         chkb(4, 8'hab);
         chkb(5, 8'hcd);
         chkb(6, 8'h0a);
         for (c = 7; c < 11; c++) chkb(c, 8'h00);
      end
      $display("test station status done");
      for (c = 1; c < 7; c++) begin
         @(posedge aclk);
         fault_code <= c[2:0];
         wait_frames(1);
         chkb(7, 8'(8'h11 + c));
      end
      @(posedge aclk);
      fault_code <= 3'h0;
      $display("test fault codes done");
      wr(`OFF_IRQ_MASK, 32'h1, 4'hf, 2'h0);
      wr(`OFF_IRQ_STAT, 32'h7, 4'hf, 2'h0);
      chk("irq cleared", irq, 1'b0);
      wr(`OFF_USER_DATA, 32'hddccbbaa, 4'hf, 2'h0);
      wr(`OFF_USER, 32'h9901, 4'h3, 2'h0);
      wait_frames(1);
      chk("irq sent", irq, 1'b1);
      chkb(7, `MSG_USER_OK);
      chkb(11, 8'h99);
      for (c = 12; c < 16; c++) chkb(c, 8'(8'haa + 8'h11 * (c - 12)));
      wr(`OFF_USER, 32'h0, 4'h1, 2'h0);
      wr(`OFF_USER, 32'h3, 4'h1, 2'h0);
      repeat (5) @(posedge aclk);
      chk("frames after 03", frames, nf[7:0]);
      chk("no send on 03", tx_valid, 1'b0);
      wr(`OFF_IRQ_STAT, 32'h1, 4'hf, 2'h0);
      chk("irq w1c", irq, 1'b0);
      $display("test host trigger done");
      // Three requests in a row: one runs, one waits, one overflows
      slow <= 1'b1;
      @(posedge aclk);
      diag_req <= 1'b1;
      repeat (3) @(posedge aclk);
      diag_req <= 1'b0;
      wait_frames(2);
      chkb(2, 8'h80);
      rd(`OFF_IRQ_STAT, d, r);
      chk("overflow", d[`IRQ_OVF], 1'b1);
      $display("test overflow done");
      conclude();
   end
endmodule
